/* File: rscl_pkg.sv */
// Package for the reset strap configuration latch.
// Assumes a 32-bit APB slave with word-aligned registers.
package rscl_pkg;

  // ---------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] RSCL_IDX_TAG = 8'h40;
  localparam logic [7:0] RSCL_IDX_CACHE = 8'h41;
  localparam logic [7:0] RSCL_IDX_CLK = 8'hED;
  localparam logic [7:0] RSCL_IDX_STAT = 8'hF0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RSCL_RST_CLK = 8'h00;
  localparam logic [7:0] RSCL_RST_CACHE = 8'h00;
  localparam logic [7:0] RSCL_RST_TAG = 8'h00;
  localparam logic RSCL_RST_PD_EN = 1'b1;

  // ---------------------------------------------------------------
  // Strap pins: vector bit 0 is host address 19
  // ---------------------------------------------------------------
  localparam int unsigned RSCL_PIN_BASE = 19;
  localparam int unsigned RSCL_NPINS = 13;
  localparam int unsigned RSCL_PIN_FREQ_LSB = 29 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_PLL = 28 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_27 = 27 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_26 = 26 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_25 = 25 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_24 = 24 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_TAG = 23 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_TYPE = 22 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_SIZE_LSB = 20 - RSCL_PIN_BASE;
  localparam int unsigned RSCL_PIN_BANK = 19 - RSCL_PIN_BASE;

  // ---------------------------------------------------------------
  // Field positions inside the registers
  // ---------------------------------------------------------------
  localparam int unsigned RSCL_CLK_FREQ_LSB = 5;
  localparam int unsigned RSCL_CLK_PLL_BIT = 4;
  localparam int unsigned RSCL_TAG_EN_BIT = 6;
  localparam int unsigned RSCL_CACHE_BANK_BIT = 5;
  localparam int unsigned RSCL_CACHE_TYPE_BIT = 4;
  localparam int unsigned RSCL_CACHE_SIZE_LSB = 2;
  localparam int unsigned RSCL_STAT_DONE_BIT = 0;
  localparam int unsigned RSCL_STAT_REV_BIT = 1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    RSCL_WAIT_REL = 1'b0,
    RSCL_CAPTURED = 1'b1
  } rscl_cap_e;

  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } rscl_wr_s;

endpackage : rscl_pkg

/* File: rscl_strap_cap.sv */
// Strap capture: snapshots the strap pins once after reset release.
// Assumes pins are synchronous to the clock and stable around release.
`timescale 1ns/10ps
module rscl_strap_cap
  import rscl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [RSCL_NPINS-1:0] i_pins,
  input wire logic [RSCL_NPINS-1:0] i_pins_drv,
  output logic o_load,
  output logic [RSCL_NPINS-1:0] o_snap
);

  typedef struct packed {
    rscl_cap_e st;
    logic load;
    logic [RSCL_NPINS-1:0] snap;
  } rscl_cap_s;

  rscl_cap_s s_q;
  rscl_cap_s s_d;

  // ---------------------------------------------------------------
  // Capture sequence
  // ---------------------------------------------------------------
  // One-shot on the first edge after release; only reset rearms it
  always_comb begin
    s_d = s_q;
    s_d.load = 1'b0;
    case (s_q.st)
      RSCL_WAIT_REL: begin
        s_d.st = RSCL_CAPTURED;
        s_d.load = 1'b1;
        // weak pull-down
        // An undriven pin reads low, as the internal pull would make it
        s_d.snap = i_pins & i_pins_drv;
      end
      default: begin
        s_d.st = RSCL_CAPTURED;
      end
    endcase
  end

  // Synchronous reset to constants only
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_q <= '{st: RSCL_WAIT_REL, load: 1'b0, snap: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_load = s_q.load;
  assign o_snap = s_q.snap;

endmodule : rscl_strap_cap

/* File: rscl_apb_slv.sv */
// APB slave front end: zero-wait access phase, registered answers.
// Assumes the owner supplies read data for the index on i_paddr.
`timescale 1ns/10ps
module rscl_apb_slv
  import rscl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_hit,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_idx,
  output rscl_wr_s o_wr,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr
);

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } rscl_apb_s;

  rscl_apb_s s_q;
  rscl_apb_s s_d;
  logic aligned;
  logic setup;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign o_idx = i_paddr[9:2];
  assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
  assign setup = i_psel && !i_penable;

  // Write commits only at the completing edge of the access phase
  assign o_wr.en = i_psel && i_penable && s_q.pready && i_pwrite &&
                   aligned && i_hit;
  assign o_wr.idx = o_idx;
  assign o_wr.data = i_pwdata[7:0];

  // Answer prepared in setup so every bus output is a flop
  always_comb begin
    s_d = s_q;
    if (setup) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !(aligned && i_hit);
      if (!i_pwrite && aligned && i_hit) begin
        s_d.prdata = {24'h000000, i_rdata};
      end else begin
        s_d.prdata = 32'h00000000;
      end
    end else if (i_psel && i_penable && s_q.pready) begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_q <= '{pready: 1'b0, prdata: 32'h00000000, pslverr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pready = s_q.pready;
  assign o_prdata = s_q.prdata;
  assign o_pslverr = s_q.pslverr;

endmodule : rscl_apb_slv

/* File: rscl_top.sv */
// Reset strap configuration latch: captures board straps into
// configuration registers at reset release, APB readable/writable.
// Assumes straps are stable and synchronous while reset is released.
//
// How it works
// - Capture straps when system reset is released
// - Undriven strap pins read as zero
// - Top three straps give bus frequency
// - Address 28 strap enables processor PLL
// - Early silicon: three-bit clock compensation code
// - Early silicon: address 24 selects PLL test
// - Later silicon: two-bit compensation in bits 3:2
// - Later silicon: data clock advance bits 1:0
// - Capture cache type, bank count, tag enable
// - Capture cache size code in bits 3:2
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module rscl_top
  import rscl_pkg::*;
#(
  parameter bit P_LATE_REV = 1'b1
)(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [RSCL_NPINS-1:0] i_host_addr_strap_pins,
  input wire logic [RSCL_NPINS-1:0] i_strap_ext_drv,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_strap_pd_en,
  output logic [2:0] o_host_freq_code,
  output logic o_cpu_pll_en,
  output logic [2:0] o_clk_comp_code,
  output logic o_pll_test_mode,
  output logic [1:0] o_host_data_clk_advance,
  output logic o_int_tag_en,
  output logic o_l2_mem_cache,
  output logic o_l2_two_bank,
  output logic [1:0] o_l2_size_code,
  output logic o_cap_done
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] clk_cfg;
    logic [7:0] cache_cfg;
    logic [7:0] tag_cfg;
    logic done;
    logic pd_en;
  } rscl_top_s;

  rscl_top_s s_q;
  rscl_top_s s_d;
  logic cap_load;
  logic [RSCL_NPINS-1:0] snap;
  logic [7:0] idx;
  rscl_wr_s wr;
  logic hit;
  logic [7:0] rdata;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  rscl_strap_cap u_cap (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pins(i_host_addr_strap_pins),
    .i_pins_drv(i_strap_ext_drv),
    .o_load(cap_load),
    .o_snap(snap)
  );

  rscl_apb_slv u_apb (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_hit(hit),
    .i_rdata(rdata),
    .o_idx(idx),
    .o_wr(wr),
    .o_pready(o_pready),
    .o_prdata(o_prdata),
    .o_pslverr(o_pslverr)
  );

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  // Status register is read-only; writes to it are silently dropped
  always_comb begin
    hit = 1'b1;
    rdata = 8'h00;
    if (idx == RSCL_IDX_CLK) begin
      rdata = s_q.clk_cfg;
    end else if (idx == RSCL_IDX_CACHE) begin
      rdata = s_q.cache_cfg;
    end else if (idx == RSCL_IDX_TAG) begin
      rdata = s_q.tag_cfg;
    end else if (idx == RSCL_IDX_STAT) begin
      rdata[RSCL_STAT_DONE_BIT] = s_q.done;
      rdata[RSCL_STAT_REV_BIT] = P_LATE_REV;
    end else begin
      hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------
  // Capture outranks software: they can only meet right after reset
  always_comb begin
    s_d = s_q;
    if (cap_load) begin
      s_d.done = 1'b1;
      s_d.clk_cfg[RSCL_CLK_FREQ_LSB +: 3] =
        snap[RSCL_PIN_FREQ_LSB +: 3];
      s_d.clk_cfg[RSCL_CLK_PLL_BIT] = snap[RSCL_PIN_PLL];
      if (P_LATE_REV) begin
        s_d.clk_cfg[3:2] = {snap[RSCL_PIN_27], snap[RSCL_PIN_26]};
        s_d.clk_cfg[1:0] = {snap[RSCL_PIN_25], snap[RSCL_PIN_24]};
      end else begin
        s_d.clk_cfg[3:1] = {snap[RSCL_PIN_27], snap[RSCL_PIN_25],
                            snap[RSCL_PIN_24]};
        s_d.clk_cfg[0] = snap[RSCL_PIN_24];
      end
      s_d.cache_cfg[RSCL_CACHE_TYPE_BIT] = snap[RSCL_PIN_TYPE];
      s_d.cache_cfg[RSCL_CACHE_BANK_BIT] = snap[RSCL_PIN_BANK];
      s_d.tag_cfg[RSCL_TAG_EN_BIT] = snap[RSCL_PIN_TAG];
      s_d.cache_cfg[RSCL_CACHE_SIZE_LSB +: 2] =
        snap[RSCL_PIN_SIZE_LSB +: 2];
    end else if (wr.en) begin
      if (wr.idx == RSCL_IDX_CLK) begin
        s_d.clk_cfg = wr.data;
      end else if (wr.idx == RSCL_IDX_CACHE) begin
        s_d.cache_cfg = wr.data;
      end else if (wr.idx == RSCL_IDX_TAG) begin
        s_d.tag_cfg = wr.data;
      end
    end
  end

  // Synchronous active-low reset to constants
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_q <= '{clk_cfg: RSCL_RST_CLK, cache_cfg: RSCL_RST_CACHE,
               tag_cfg: RSCL_RST_TAG, done: 1'b0,
               pd_en: RSCL_RST_PD_EN};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, slices of registered state; fields unused by the revision tie to zero
  // ---------------------------------------------------------------
  // pull-down enable
  assign o_strap_pd_en = s_q.pd_en;
  assign o_host_freq_code = s_q.clk_cfg[RSCL_CLK_FREQ_LSB +: 3];
  assign o_cpu_pll_en = s_q.clk_cfg[RSCL_CLK_PLL_BIT];
  // Later silicon uses only bits 3:2, zero-extended to the code
  assign o_clk_comp_code = P_LATE_REV ?
                           {1'b0, s_q.clk_cfg[3:2]} : s_q.clk_cfg[3:1];
  assign o_pll_test_mode = P_LATE_REV ? 1'b0 : s_q.clk_cfg[0];
  assign o_host_data_clk_advance = P_LATE_REV ? s_q.clk_cfg[1:0] : 2'h0;
  assign o_int_tag_en = s_q.tag_cfg[RSCL_TAG_EN_BIT];
  assign o_l2_mem_cache = s_q.cache_cfg[RSCL_CACHE_TYPE_BIT];
  assign o_l2_two_bank = s_q.cache_cfg[RSCL_CACHE_BANK_BIT];
  assign o_l2_size_code = s_q.cache_cfg[RSCL_CACHE_SIZE_LSB +: 2];
  assign o_cap_done = s_q.done;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // One clock domain; reset low disables every check
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Strap value as the pad sees it, pull-down included
  logic [RSCL_NPINS-1:0] eff;
  assign eff = i_host_addr_strap_pins & i_strap_ext_drv;

  // Capture lands exactly two edges after release
  chk_capture_at_release: assert property (
    $rose(i_rst_n) |-> ##2 (o_cap_done && $past(cap_load)))
    else $error("capture not done two edges after release");

  // Undriven pins read low, driven ones as driven
  chk_pulldown_undriven: assert property (
    (o_strap_pd_en && ($past(i_rst_n) == 1'b0)) |=>
      ((snap & ~$past(i_strap_ext_drv)) == '0) &&
      ((snap & $past(i_strap_ext_drv)) == $past(eff)))
    else $error("undriven strap not read as zero");

  // Pad pull stays on while running
  chk_pulldown_on: assert property (
    o_strap_pd_en)
    else $error("strap pull-down switched off");

  // Clock register fields follow their pins
  chk_freq_code: assert property (
    cap_load |=> o_host_freq_code == $past(snap[RSCL_PIN_FREQ_LSB +: 3]))
    else $error("frequency code mismatch");

  chk_pll_enable: assert property (
    cap_load |=> o_cpu_pll_en == $past(snap[RSCL_PIN_PLL]))
    else $error("PLL enable mismatch");

  chk_early_comp: assert property (
    (cap_load && !P_LATE_REV) |=> o_clk_comp_code ==
      $past({snap[RSCL_PIN_27], snap[RSCL_PIN_25], snap[RSCL_PIN_24]}))
    else $error("early compensation code mismatch");

  chk_early_test: assert property (
    (cap_load && !P_LATE_REV) |=> o_pll_test_mode ==
      $past(snap[RSCL_PIN_24]))
    else $error("PLL test select mismatch");

  chk_late_comp: assert property (
    (cap_load && P_LATE_REV) |=> s_q.clk_cfg[3:2] ==
      $past({snap[RSCL_PIN_27], snap[RSCL_PIN_26]}))
    else $error("late compensation code mismatch");

  chk_late_advance: assert property (
    (cap_load && P_LATE_REV) |=> o_host_data_clk_advance ==
      $past({snap[RSCL_PIN_25], snap[RSCL_PIN_24]}))
    else $error("data clock advance mismatch");

  // Cache and tag fields follow their pins
  chk_cache_bits: assert property (
    cap_load |=> (o_l2_mem_cache == $past(snap[RSCL_PIN_TYPE])) &&
      (o_l2_two_bank == $past(snap[RSCL_PIN_BANK])) &&
      (o_int_tag_en == $past(snap[RSCL_PIN_TAG])))
    else $error("cache strap bits mismatch");

  chk_cache_size: assert property (
    cap_load |=> o_l2_size_code == $past(snap[RSCL_PIN_SIZE_LSB +: 2]))
    else $error("cache size code mismatch");

  // Captured values only move on a software write
  chk_hold_no_write: assert property (
    (o_cap_done && !cap_load && !wr.en) |=> $stable(s_q.clk_cfg) &&
      $stable(s_q.cache_cfg) && $stable(s_q.tag_cfg))
    else $error("captured field changed without a write");

  chk_single_capture: assert property (
    o_cap_done |-> !cap_load)
    else $error("second capture without reset");

  // A completed write reaches the clock register
  chk_write_lands: assert property (
    (wr.en && !cap_load && (wr.idx == RSCL_IDX_CLK)) |=>
      (s_q.clk_cfg == $past(wr.data)))
    else $error("clock register write lost");

  // Bus: one-cycle answer, refusals carry no data
  chk_apb_answer: assert property (
    (i_psel && !i_penable) |=> o_pready)
    else $error("access phase not answered in one cycle");

  // Ready never stretches past the access cycle
  chk_ready_single: assert property (
    o_pready |=> !o_pready)
    else $error("ready held beyond the access cycle");

  chk_error_no_data: assert property (
    o_pslverr |-> (o_pready && (o_prdata == 32'h00000000)))
    else $error("refused access returned data or no ready");

  // A refused access never writes
  chk_refused_write: assert property (
    (i_psel && i_penable && o_pready && o_pslverr) |-> !wr.en)
    else $error("refused access wrote a register");

  // Main scenarios
  cov_capture: cover property ($rose(i_rst_n) ##2 o_cap_done);
  cov_sw_write: cover property (o_cap_done && wr.en &&
    wr.idx == RSCL_IDX_CLK);
  cov_bad_addr: cover property (o_pready && o_pslverr);
  cov_pll_on: cover property (cap_load ##1 o_cpu_pll_en);
  cov_refused_write: cover property (i_pwrite && o_pslverr);

endmodule : rscl_top

/* File: rscl_strap_board.sv */
// Board strap model: resistors on the host address strap pins.
// Assumes the bench picks which pins carry a resistor and its level.
`timescale 1ns/10ps
module rscl_strap_board
  import rscl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [RSCL_NPINS-1:0] i_level,
  input wire logic [RSCL_NPINS-1:0] i_fit,
  output logic [RSCL_NPINS-1:0] o_pins,
  output logic [RSCL_NPINS-1:0] o_drv
);
  // -------------------------------------------------------------
  // Pin levels
  // -------------------------------------------------------------
  logic [RSCL_NPINS-1:0] noise_q = '0;

  // Unfitted pins flip every cycle, so only the device pull decides
  always_ff @(posedge i_ref_clk) begin
    noise_q <= ~noise_q;
  end

  // Fitted pins show their resistor level
  assign o_pins = (i_level & i_fit) | (noise_q & ~i_fit);
  assign o_drv = i_fit;
endmodule : rscl_strap_board

/* File: tb.sv */
// Testbench: random strap captures, register access and overrides.
// Assumes a late instance uut and an early instance sharing the bus.
`timescale 1ns/10ps
module tb;
  import rscl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] level, fit, pins, drv, lv, ft, p;
  logic pready, pslverr;
  wire [16:0] cfg_l, cfg_e;
  int n_mismatch, total_checks;
  localparam logic [11:0] A_CLK = {2'b00, RSCL_IDX_CLK, 2'b00};
  localparam logic [11:0] A_CACHE = {2'b00, RSCL_IDX_CACHE, 2'b00};
  localparam logic [11:0] A_TAG = {2'b00, RSCL_IDX_TAG, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, RSCL_IDX_STAT, 2'b00};

  // Clock at 200 MHz
  always #2.5 ref_clk = ~ref_clk;

  rscl_strap_board board (.i_ref_clk(ref_clk), .i_level(level),
    .i_fit(fit), .o_pins(pins), .o_drv(drv));

  rscl_top #(.P_LATE_REV(1'b1)) uut (.i_ref_clk(ref_clk),
    .i_rst_n(rst_n), .i_host_addr_strap_pins(pins), .i_strap_ext_drv(drv),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_strap_pd_en(cfg_l[0]),
    .o_host_freq_code(cfg_l[16:14]), .o_cpu_pll_en(cfg_l[13]),
    .o_clk_comp_code(cfg_l[12:10]), .o_pll_test_mode(cfg_l[9]),
    .o_host_data_clk_advance(cfg_l[8:7]), .o_int_tag_en(cfg_l[6]),
    .o_l2_mem_cache(cfg_l[5]), .o_l2_two_bank(cfg_l[4]),
    .o_l2_size_code(cfg_l[3:2]), .o_cap_done(cfg_l[1]));

  rscl_top #(.P_LATE_REV(1'b0)) uut_early (.i_ref_clk(ref_clk),
    .i_rst_n(rst_n), .i_host_addr_strap_pins(pins), .i_strap_ext_drv(drv),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(), .o_prdata(),
    .o_pslverr(), .o_strap_pd_en(cfg_e[0]),
    .o_host_freq_code(cfg_e[16:14]), .o_cpu_pll_en(cfg_e[13]),
    .o_clk_comp_code(cfg_e[12:10]), .o_pll_test_mode(cfg_e[9]),
    .o_host_data_clk_advance(cfg_e[8:7]), .o_int_tag_en(cfg_e[6]),
    .o_l2_mem_cache(cfg_e[5]), .o_l2_two_bank(cfg_e[4]),
    .o_l2_size_code(cfg_e[3:2]), .o_cap_done(cfg_e[1]));

  // -------------------------------------------------------------
  // Expectations
  // -------------------------------------------------------------
  // Clock register from straps; bit 0 of pins is host address 19
  function automatic logic [7:0] clk_of(input logic [12:0] s,
                                        input logic late);
    return late ? {s[12:8], s[7], s[6], s[5]} : {s[12:8], s[6], s[5], s[5]};
  endfunction : clk_of

  // Output fields from register contents
  function automatic logic [16:0] cfg_of(input logic [7:0] c,
      input logic [7:0] ca, input logic [7:0] tg, input logic late);
    return {c[7:5], c[4], late ? {1'b0, c[3:2]} : c[3:1],
            late ? 1'b0 : c[0], late ? c[1:0] : 2'b00, tg[6], ca[4],
            ca[5], ca[3:2], 2'b11};
  endfunction : cfg_of

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, the watchdog bounds a hang
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reset, release, then disturb straps after the capture edge
  task automatic capture(input logic [12:0] l, input logic [12:0] f);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    level <= l;
    fit <= f;
    repeat (3) @(posedge ref_clk);
    chk(cfg_l[1:0], 32'h1);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    level <= ~l;
    repeat (2) @(posedge ref_clk);
  endtask : capture

  task automatic check_all(input logic [7:0] cl, input logic [7:0] ce,
                           input logic [7:0] ca, input logic [7:0] tg);
    chk(cfg_l, cfg_of(cl, ca, tg, 1'b1));
    chk(cfg_e, cfg_of(ce, ca, tg, 1'b0));
    apb(1'b0, A_CLK, 8'h00);
    chk(rd, {24'h000000, cl});
    apb(1'b0, A_CACHE, 8'h00);
    chk(rd, {24'h000000, ca});
    apb(1'b0, A_TAG, 8'h00);
    chk(rd, {24'h000000, tg});
    apb(1'b0, A_STAT, 8'h00);
    chk(rd, 32'h3);
  endtask : check_all

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    level = '0;
    fit = '0;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(32'h9CFE8882));
    for (int t = 0; t < 8; t++) begin
      lv = 13'($urandom);
      ft = 13'($urandom);
      // Corner cases: nothing fitted, then everything pulled high
      if (t == 0) begin
        lv = '1;
        ft = '0;
      end
      if (t == 1) begin
        lv = '1;
        ft = '1;
      end
      capture(lv, ft);
      p = lv & ft;
      check_all(clk_of(p, 1'b1), clk_of(p, 1'b0),
                {2'b00, p[0], p[3], p[2:1], 2'b00}, {1'b0, p[4], 6'h00});
      // Software override, refusals, then later resets recapture
      if (t == 3) begin
        apb(1'b1, A_CLK, 8'hA5);
        chk(err, 32'h0);
        apb(1'b1, A_CACHE, 8'hFF);
        apb(1'b1, A_TAG, 8'h3C);
        apb(1'b1, A_STAT, 8'hFF);
        chk(err, 32'h0);
        apb(1'b0, 12'h200, 8'h00);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h105, 8'h00);
        chk(err, 32'h1);
        check_all(8'hA5, 8'hA5, 8'hFF, 8'h3C);
      end
      $display("capture test %0d done", t);
    end
    close_out();
  end
endmodule : tb
